// ===== src/wdam_pkg.sv
// constants and types of the watchdog arm and monitor flag registers
// Notes on behaviour
// - service register always reads zero
// - rate zero: service writes ignored entirely
// - enabled, bad service byte resets at once
// - 0x55 then 0xaa restarts the period
// - pair must finish before period expires
// - repeated 0x55 writes keep sequence armed
// - window mode: early service write resets
// - select bit picks bandgap only with sensor enabled, else temperature
// - sensor enable powers sensor and amplifier
// - temperature level read-only, follows comparator
// - temperature flag sets on change, w1c
// - temperature enable gates its interrupt request
// - temperature control bits writable any time
// - low-voltage level read-only, follows comparator
// - low-voltage flag sets on change, w1c
// - low-voltage enable gates its interrupt request
// - low-voltage bits after reset follow supply
// - nonzero rate enables and starts watchdog
package wdam_pkg;
  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_SERVICE = 8'h0f;
  localparam logic [7:0] IDX_TEMP_CTL = 8'h10;
  localparam logic [7:0] IDX_LV_CTL = 8'h11;
  localparam logic [7:0] IDX_WDG_CFG = 8'h0c;
  localparam logic [7:0] IDX_IRQ_STAT = 8'h18;
  localparam logic [7:0] IDX_IRQ_MASK = 8'h19;
  // control register fields
  localparam int BIT_FLAG = 0;
  localparam int BIT_IE = 1;
  localparam int BIT_LEVEL = 2;
  localparam int BIT_SENS_EN = 3;
  localparam int BIT_VOLTAGE_SELECT_BIT = 5;
  localparam int BIT_WINDOW = 7;
  localparam logic [2:0] RATE_OFF = 3'h0;
  // service sequence bytes
  localparam logic [7:0] SVC_ARM = 8'h55;
  localparam logic [7:0] SVC_FIRE = 8'haa;
  // sticky status bits
  localparam int ST_TEMP = 0;
  localparam int ST_LV = 1;
  localparam int ST_SVC = 2;
  localparam int ST_W = 3;
  // reset values
  localparam logic [7:0] RST_TEMP_CTL = 8'h00;
  localparam logic [3:0] RST_WDG_CFG = 4'h0;
  localparam logic [ST_W-1:0] RST_MASK = 3'h0;
  localparam int CNT_W = 25;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

  typedef struct packed {
    logic valid;
    logic write;
    logic [7:0] idx;
  } wdam_aphase_s;

  typedef struct packed {
    logic level;
    logic flag;
    logic ie;
  } wdam_mon_s;
endpackage

// ===== src/wdam_top.sv
// watchdog arm, temperature and low-voltage monitor register block
`timescale 1ns/100ps
module wdam_top #(
  // log2 of the time-out length in clock cycles, rates 1 to 7
  parameter int RATE_LOG2_1 = 14,
  parameter int RATE_LOG2_2 = 16,
  parameter int RATE_LOG2_3 = 18,
  parameter int RATE_LOG2_4 = 20,
  parameter int RATE_LOG2_5 = 22,
  parameter int RATE_LOG2_6 = 23,
  parameter int RATE_LOG2_7 = 24
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // analog comparators
  input wire logic tempAbove,
  input wire logic supplyLow,
  // analog controls
  output logic sensorEnable,
  output logic bandgapSelect,
  // system
  output logic watchdogReset,
  output logic irq
);
  import wdam_pkg::*;

  logic [1:0] rstSync_ff;
  logic rstN;
  wdam_aphase_s aph_ff;
  logic rdWait_ff;
  logic [31:0] hrdata_ff;
  logic hreadyout_ff;
  logic [2:0] tempSync_ff;
  logic [2:0] lvSync_ff;
  logic primed_ff;
  wdam_mon_s temp_ff;
  wdam_mon_s lv_ff;
  logic sensEn_ff;
  logic voltage_select_bit_ff;
  logic bandgapSel_ff;
  logic [2:0] rate_ff;
  logic window_ff;
  logic [CNT_W-1:0] cnt_ff;
  logic armed_ff;
  logic wdgRst_ff;
  logic [ST_W-1:0] stat_ff;
  logic [ST_W-1:0] mask_ff;
  logic irq_ff;
  logic [ST_W-1:0] evt;
  logic wrStb;
  logic [7:0] wb;
  logic svcWr;
  logic wdgOn;
  logic [CNT_W-1:0] periodM1;
  logic [CNT_W-1:0] threeQ;
  logic early;
  logic restart;
  logic badWrite;
  logic expiry;
  logic tempChg;
  logic lvChg;
  logic rdStat;
  logic [7:0] rdByte;

  // time-out length for a rate code
  function automatic logic [CNT_W-1:0] rateLen(input logic [2:0] r);
    int sh;
    sh = RATE_LOG2_7;
    case (r)
      3'h1: sh = RATE_LOG2_1;
      3'h2: sh = RATE_LOG2_2;
      3'h3: sh = RATE_LOG2_3;
      3'h4: sh = RATE_LOG2_4;
      3'h5: sh = RATE_LOG2_5;
      3'h6: sh = RATE_LOG2_6;
      default: sh = RATE_LOG2_7;
    endcase
    return CNT_W'(sh >= CNT_W ? 0 : (32'h1 << sh));
  endfunction

  // reset release through two flip-flops
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      rstSync_ff <= 2'h0;
    end else begin
      rstSync_ff <= {rstSync_ff[0], 1'b1};
    end
  end
  assign rstN = rstSync_ff[1];

  // address phase capture and read wait state
  always_ff @(posedge core_clk or negedge rstN) begin
    if (!rstN) begin
      aph_ff <= '0;
      rdWait_ff <= 1'b0;
      hreadyout_ff <= 1'b1;
    end else begin
      if (hready && hreadyout_ff) begin
        aph_ff.valid <= hsel && (htrans == HTRANS_NONSEQ);
        aph_ff.write <= hwrite;
        aph_ff.idx <= haddr[9:2];
        rdWait_ff <= hsel && (htrans == HTRANS_NONSEQ) && !hwrite;
        hreadyout_ff <= !(hsel && (htrans == HTRANS_NONSEQ) && !hwrite);
      end else if (rdWait_ff) begin
        rdWait_ff <= 1'b0;
        aph_ff.valid <= 1'b0;
        hreadyout_ff <= 1'b1;
      end
    end
  end

  assign wrStb = aph_ff.valid && aph_ff.write;
  assign wb = hwdata[7:0];
  assign svcWr = wrStb && (aph_ff.idx == IDX_SERVICE);
  assign rdStat = rdWait_ff && (aph_ff.idx == IDX_IRQ_STAT);

  // read data mux
  always_comb begin
    rdByte = 8'h00;
    if (aph_ff.idx == IDX_SERVICE) begin
      rdByte = 8'h00;
    end else if (aph_ff.idx == IDX_TEMP_CTL) begin
      rdByte[BIT_VOLTAGE_SELECT_BIT] = voltage_select_bit_ff;
      rdByte[BIT_SENS_EN] = sensEn_ff;
      rdByte[BIT_LEVEL] = temp_ff.level;
      rdByte[BIT_IE] = temp_ff.ie;
      rdByte[BIT_FLAG] = temp_ff.flag;
    end else if (aph_ff.idx == IDX_LV_CTL) begin
      rdByte[BIT_LEVEL] = lv_ff.level;
      rdByte[BIT_IE] = lv_ff.ie;
      rdByte[BIT_FLAG] = lv_ff.flag;
    end else if (aph_ff.idx == IDX_WDG_CFG) begin
      rdByte[BIT_WINDOW] = window_ff;
      rdByte[2:0] = rate_ff;
    end else if (aph_ff.idx == IDX_IRQ_STAT) begin
      rdByte[ST_W-1:0] = stat_ff;
    end else if (aph_ff.idx == IDX_IRQ_MASK) begin
      rdByte[ST_W-1:0] = mask_ff;
    end
  end

  always_ff @(posedge core_clk or negedge rstN) begin
    if (!rstN) begin
      hrdata_ff <= 32'h0;
    end else if (rdWait_ff) begin
      hrdata_ff <= {24'h0, rdByte};
    end
  end

  always_ff @(posedge core_clk or negedge rstN) begin
    if (!rstN) begin
      tempSync_ff <= 3'h0;
      lvSync_ff <= 3'h0;
      primed_ff <= 1'b0;
    end else begin
      tempSync_ff <= {tempSync_ff[1:0], tempAbove};
      lvSync_ff <= {lvSync_ff[1:0], supplyLow};
      primed_ff <= 1'b1;
    end
  end

  // change counted once stages two and three agree
  assign tempChg = primed_ff && (tempSync_ff[2] == tempSync_ff[1])
                   && (tempSync_ff[2] != temp_ff.level);
  assign lvChg = primed_ff && (lvSync_ff[2] == lvSync_ff[1])
                 && (lvSync_ff[2] != lv_ff.level);

  // temperature monitor register
  always_ff @(posedge core_clk or negedge rstN) begin
    if (!rstN) begin
      temp_ff <= '0;
      sensEn_ff <= RST_TEMP_CTL[BIT_SENS_EN];
      voltage_select_bit_ff <= RST_TEMP_CTL[BIT_VOLTAGE_SELECT_BIT];
      bandgapSel_ff <= RST_TEMP_CTL[BIT_VOLTAGE_SELECT_BIT] && RST_TEMP_CTL[BIT_SENS_EN];
    end else begin
      if (wrStb && aph_ff.idx == IDX_TEMP_CTL) begin
        voltage_select_bit_ff <= wb[BIT_VOLTAGE_SELECT_BIT];
        sensEn_ff <= wb[BIT_SENS_EN];
        temp_ff.ie <= wb[BIT_IE];
        // bandgap route only with sensor on
        bandgapSel_ff <= wb[BIT_VOLTAGE_SELECT_BIT] && wb[BIT_SENS_EN];
      end
      if (tempChg) begin
        temp_ff.level <= tempSync_ff[2];
      end
      if (tempChg) begin
        temp_ff.flag <= 1'b1;
      end else if (wrStb && aph_ff.idx == IDX_TEMP_CTL && wb[BIT_FLAG]) begin
        temp_ff.flag <= 1'b0;
      end
    end
  end

  // low-voltage monitor register
  always_ff @(posedge core_clk or negedge rstN) begin
    if (!rstN) begin
      lv_ff <= '0;
    end else begin
      if (wrStb && aph_ff.idx == IDX_LV_CTL) begin
        lv_ff.ie <= wb[BIT_IE];
      end
      // a low supply seen after reset loads level and sets flag
      if (lvChg) begin
        lv_ff.level <= lvSync_ff[2];
      end
      if (lvChg) begin
        lv_ff.flag <= 1'b1;
      end else if (wrStb && aph_ff.idx == IDX_LV_CTL && wb[BIT_FLAG]) begin
        lv_ff.flag <= 1'b0;
      end
    end
  end

  // watchdog configuration
  always_ff @(posedge core_clk or negedge rstN) begin
    if (!rstN) begin
      rate_ff <= RST_WDG_CFG[2:0];
      window_ff <= RST_WDG_CFG[3];
    end else if (wrStb && aph_ff.idx == IDX_WDG_CFG) begin
      rate_ff <= wb[2:0];
      window_ff <= wb[BIT_WINDOW];
    end
  end

  assign wdgOn = (rate_ff != RATE_OFF);
  assign periodM1 = rateLen(rate_ff) - CNT_W'(1);
  assign threeQ = periodM1 - (periodM1 >> 2);
  // first three quarters of the period
  assign early = window_ff && (cnt_ff < threeQ);
  // nothing happens while the rate is zero
  // wrong byte or early write resets
  assign badWrite = svcWr && wdgOn
                    && (early || (wb != SVC_ARM && wb != SVC_FIRE));
  // fire byte after arm byte restarts
  assign restart = svcWr && wdgOn && !badWrite && wb == SVC_FIRE
                   && armed_ff;
  assign expiry = wdgOn && (cnt_ff == periodM1);

  // watchdog sequence and counter
  always_ff @(posedge core_clk or negedge rstN) begin
    if (!rstN) begin
      cnt_ff <= '0;
      armed_ff <= 1'b0;
      wdgRst_ff <= 1'b0;
    end else begin
      wdgRst_ff <= badWrite || expiry;
      // nonzero rate write starts the period
      if (!wdgOn || restart || expiry || badWrite
          || (wrStb && aph_ff.idx == IDX_WDG_CFG)) begin
        cnt_ff <= '0;
      end else begin
        cnt_ff <= cnt_ff + CNT_W'(1);
      end
      if (!wdgOn || restart || badWrite || expiry) begin
        armed_ff <= 1'b0;
      end else if (svcWr && wb == SVC_ARM) begin
        armed_ff <= 1'b1;
      end
    end
  end

  assign evt[ST_TEMP] = tempChg;
  assign evt[ST_LV] = lvChg;
  assign evt[ST_SVC] = restart;

  // sticky status, cleared by reading, set wins
  always_ff @(posedge core_clk or negedge rstN) begin
    if (!rstN) begin
      stat_ff <= '0;
      mask_ff <= RST_MASK;
    end else begin
      stat_ff <= (rdStat ? '0 : stat_ff) | evt;
      if (wrStb && aph_ff.idx == IDX_IRQ_MASK) begin
        mask_ff <= wb[ST_W-1:0];
      end
    end
  end

  // interrupt output
  always_ff @(posedge core_clk or negedge rstN) begin
    if (!rstN) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= (temp_ff.flag && temp_ff.ie) || (lv_ff.flag && lv_ff.ie)
                || (|(stat_ff & mask_ff));
    end
  end

  assign hrdata = hrdata_ff;
  assign hreadyout = hreadyout_ff;
  assign hresp = 1'b0;
  assign sensorEnable = sensEn_ff;
  assign bandgapSelect = bandgapSel_ff;
  assign watchdogReset = wdgRst_ff;
  assign irq = irq_ff;
endmodule

// ===== verif/wdam_top_asserts.sv
// port checks for the watchdog and monitor register block
`timescale 1ns/100ps
module wdam_top_asserts (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // bus
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  // outputs
  input wire logic sensorEnable,
  input wire logic bandgapSelect,
  input wire logic watchdogReset,
  input wire logic irq
);
  import wdam_pkg::*;
  logic taken;
  assign taken = hsel && htrans == HTRANS_NONSEQ && hready && hreadyout;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  okay_resp_a: assert property (hresp == 1'b0)
    else $error("bus response not okay");
  read_wait_a: assert property (taken && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read data phase not two cycles");
  write_nowait_a: assert property (taken && hwrite |=> hreadyout)
    else $error("write data phase stalled");
  service_zero_a: assert property (
    taken && !hwrite && haddr[9:2] == IDX_SERVICE |-> ##2 hrdata == 32'h0)
    else $error("service register read not zero");
  upper_zero_a: assert property ($rose(hreadyout) |-> hrdata[31:8] == 24'h0)
    else $error("read data upper bits not zero");
  rdata_hold_a: assert property (hreadyout && $past(hreadyout) |->
    $stable(hrdata)) else $error("read data changed outside a read");
  reset_pulse_a: assert property (watchdogReset |=> !watchdogReset)
    else $error("watchdog reset longer than one cycle");
  bandgap_en_a: assert property (bandgapSelect |-> sensorEnable)
    else $error("bandgap selected while sensor off");
  cover property (taken && !hwrite);
  cover property ($rose(watchdogReset));
  cover property ($rose(irq));
endmodule

bind wdam_top wdam_top_asserts u_chk (
  .core_clk(core_clk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata),
  .hreadyout(hreadyout), .hresp(hresp), .sensorEnable(sensorEnable),
  .bandgapSelect(bandgapSelect), .watchdogReset(watchdogReset), .irq(irq)
);

// ===== verif/wdam_top_tb.sv
// self-checking bench for the watchdog and monitor register block
`timescale 1ns/100ps
module wdam_top_tb;
  import wdam_pkg::*;
  logic core_clk, reset_n, hsel, hwrite, tempAbove, supplyLow;
  logic [31:0] haddr, hwdata, hrdata, r;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic hreadyout, hresp, sensorEnable, bandgapSelect, watchdogReset, irq;
  int miscompares = 0;
  int checksDone = 0;
  int rstCount = 0;

  wdam_top #(.RATE_LOG2_1(8), .RATE_LOG2_2(9)) DUT (
    .core_clk(core_clk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hreadyout),
    .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .tempAbove(tempAbove), .supplyLow(supplyLow),
    .sensorEnable(sensorEnable), .bandgapSelect(bandgapSelect),
    .watchdogReset(watchdogReset), .irq(irq)
  );

  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  always @(posedge core_clk) begin
    if (watchdogReset === 1'b1) begin
      rstCount <= rstCount + 1;
    end
  end

  task stop_test;
    $display("checks %0d miscompares %0d", checksDone, miscompares);
    if (miscompares == 0 && checksDone > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    checksDone++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task ckb(input logic got, input logic exp);
    chk({31'h0, got}, {31'h0, exp});
  endtask

  task cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  task bus(input logic w, input logic [7:0] idx, input logic [7:0] d);
    @(posedge core_clk);
    hsel <= 1'b1;
    htrans <= HTRANS_NONSEQ;
    hwrite <= w;
    haddr <= {22'h0, idx, 2'h0};
    @(posedge core_clk);
    while (hreadyout !== 1'b1) @(posedge core_clk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    @(posedge core_clk);
    while (hreadyout !== 1'b1) @(posedge core_clk);
    r = hrdata;
  endtask

  task wr(input logic [7:0] idx, input logic [7:0] d);
    bus(1'b1, idx, d);
  endtask

  task rd(input logic [7:0] idx, input logic [7:0] exp);
    bus(1'b0, idx, 8'h00);
    chk(r, {24'h0, exp});
  endtask

  initial begin
    repeat (20000) @(posedge core_clk);
    miscompares++;
    stop_test;
  end

  initial begin
    reset_n = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    tempAbove = 1'b0;
    supplyLow = 1'b1;
    cyc(12);
    reset_n <= 1'b1;
    cyc(8);
    // low-voltage monitor
    rd(IDX_LV_CTL, 8'h05);
    wr(IDX_LV_CTL, 8'h01);
    rd(IDX_LV_CTL, 8'h04);
    wr(IDX_LV_CTL, 8'h02);
    supplyLow <= 1'b0;
    cyc(8);
    ckb(irq, 1'b1);
    wr(IDX_LV_CTL, 8'h02);
    rd(IDX_LV_CTL, 8'h03);
    wr(IDX_LV_CTL, 8'h01);
    cyc(2);
    ckb(irq, 1'b0);
    // temperature monitor
    wr(IDX_TEMP_CTL, 8'h2f);
    rd(IDX_TEMP_CTL, 8'h2a);
    chk({30'h0, sensorEnable, bandgapSelect}, 32'h3);
    wr(IDX_TEMP_CTL, 8'h22);
    cyc(2);
    chk({30'h0, sensorEnable, bandgapSelect}, 32'h0);
    tempAbove <= 1'b1;
    cyc(8);
    rd(IDX_TEMP_CTL, 8'h27);
    ckb(irq, 1'b1);
    wr(IDX_TEMP_CTL, 8'h20);
    cyc(2);
    ckb(irq, 1'b0);
    rd(IDX_TEMP_CTL, 8'h25);
    wr(IDX_TEMP_CTL, 8'h21);
    rd(IDX_TEMP_CTL, 8'h24);
    // status and mask
    wr(IDX_IRQ_MASK, 8'h01);
    cyc(2);
    ckb(irq, 1'b1);
    rd(IDX_IRQ_STAT, 8'h03);
    cyc(2);
    ckb(irq, 1'b0);
    rd(IDX_IRQ_STAT, 8'h00);
    rd(IDX_IRQ_MASK, 8'h01);
    // watchdog
    wr(IDX_SERVICE, 8'h12);
    cyc(4);
    chk(rstCount, 0);
    rd(IDX_SERVICE, 8'h00);
    wr(IDX_WDG_CFG, 8'h01);
    wr(IDX_SERVICE, SVC_FIRE);
    rd(IDX_IRQ_STAT, 8'h00);
    repeat (3) begin
      cyc(100);
      wr(IDX_SERVICE, SVC_ARM);
      wr(IDX_SERVICE, SVC_ARM);
      rd(8'h05, 8'h00);
      wr(IDX_SERVICE, SVC_FIRE);
    end
    chk(rstCount, 0);
    rd(IDX_IRQ_STAT, 8'h04);
    wr(IDX_SERVICE, 8'h12);
    cyc(4);
    chk(rstCount, 1);
    cyc(300);
    chk(rstCount, 2);
    wr(IDX_WDG_CFG, 8'h81);
    wr(IDX_SERVICE, SVC_ARM);
    cyc(4);
    chk(rstCount, 3);
    wr(IDX_WDG_CFG, 8'h81);
    cyc(200);
    wr(IDX_SERVICE, SVC_ARM);
    wr(IDX_SERVICE, SVC_FIRE);
    cyc(150);
    chk(rstCount, 3);
    wr(IDX_SERVICE, SVC_ARM);
    cyc(4);
    chk(rstCount, 4);
    rd(IDX_WDG_CFG, 8'h81);
    wr(IDX_WDG_CFG, 8'h02);
    cyc(400);
    chk(rstCount, 4);
    cyc(150);
    chk(rstCount, 5);
    wr(IDX_WDG_CFG, 8'h00);
    stop_test;
  end
endmodule
